// ### rtl/ulrsd_top.sv
// Line resistor enable decoder with its control and status registers.
// Assumes a link-side master on the same clock driving one-cycle strobes.
`timescale 1ns/1ns
module ulrsd_top
	import ulrsd_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [ULRSD_AW-1:0] reg_addr,
	input wire logic [ULRSD_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [ULRSD_DW-1:0] reg_rdata,
	output logic plus_line_pullup_enable,
	output logic plus_line_15k_pd_enable,
	output logic minus_line_15k_pd_enable,
	output logic fast_termination_enable
);

	// ****************************************
	// Reset release
	// ****************************************
	logic rst_meta_b_r;
	logic rst_sync_b_r;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_b_r <= 1'b0;
			rst_sync_b_r <= 1'b0;
		end else begin
			rst_meta_b_r <= 1'b1;
			rst_sync_b_r <= rst_meta_b_r;
		end
	end

	// ****************************************
	// Line-state controls
	// ****************************************
	logic [1:0] transceiver_speed_select_r;
	logic termination_select_r;
	logic [1:0] line_drive_mode_r;
	logic plus_line_pd_request_r;
	logic minus_line_pd_request_r;
	logic ctrl_hit;

	assign ctrl_hit = reg_wr && (reg_addr == ULRSD_CTRL_OFS);

	always_ff @(posedge clk or negedge rst_sync_b_r) begin
		if (!rst_sync_b_r) begin
			transceiver_speed_select_r <= ULRSD_XCVR_RST;
			termination_select_r <= ULRSD_TERM_RST;
			line_drive_mode_r <= ULRSD_MODE_RST;
			plus_line_pd_request_r <= ULRSD_PPD_RST;
			minus_line_pd_request_r <= ULRSD_MPD_RST;
		end else if (ctrl_hit) begin
			transceiver_speed_select_r <= reg_wdata[ULRSD_XCVR_LSB +: 2];
			termination_select_r <= reg_wdata[ULRSD_TERM_BIT];
			line_drive_mode_r <= reg_wdata[ULRSD_MODE_LSB +: 2];
			plus_line_pd_request_r <= reg_wdata[ULRSD_PPD_BIT];
			minus_line_pd_request_r <= reg_wdata[ULRSD_MPD_BIT];
		end
	end

	// ****************************************
	// Resistor decode
	// ****************************************
	logic pu_nxt;
	logic ppd_nxt;
	logic mpd_nxt;
	logic fterm_nxt;

	always_comb begin
		if (line_drive_mode_r == ULRSD_MODE_NODRIVE) begin
			pu_nxt = 1'b0;
			ppd_nxt = 1'b0;
			mpd_nxt = 1'b0;
			fterm_nxt = 1'b0;
		end else begin
			// Pull-up only as a device with its own pull-down released
			pu_nxt = termination_select_r && !plus_line_pd_request_r;
			ppd_nxt = plus_line_pd_request_r;
			mpd_nxt = minus_line_pd_request_r;
			fterm_nxt = (transceiver_speed_select_r == ULRSD_XCVR_HS) && !termination_select_r;
		end
	end

	always_ff @(posedge clk or negedge rst_sync_b_r) begin
		if (!rst_sync_b_r) begin
			plus_line_pullup_enable <= ULRSD_PU_EN_RST;
			plus_line_15k_pd_enable <= ULRSD_PPD_EN_RST;
			minus_line_15k_pd_enable <= ULRSD_MPD_EN_RST;
			fast_termination_enable <= ULRSD_FTERM_EN_RST;
		end else begin
			plus_line_pullup_enable <= pu_nxt;
			plus_line_15k_pd_enable <= ppd_nxt;
			minus_line_15k_pd_enable <= mpd_nxt;
			fast_termination_enable <= fterm_nxt;
		end
	end

	// ****************************************
	// Read port
	// ****************************************
	logic [ULRSD_DW-1:0] rdata_nxt;

	always_comb begin
		rdata_nxt = '0;
		if (reg_rd) begin
			case (reg_addr)
				ULRSD_CTRL_OFS: begin
					rdata_nxt[ULRSD_XCVR_LSB +: 2] = transceiver_speed_select_r;
					rdata_nxt[ULRSD_TERM_BIT] = termination_select_r;
					rdata_nxt[ULRSD_MODE_LSB +: 2] = line_drive_mode_r;
					rdata_nxt[ULRSD_PPD_BIT] = plus_line_pd_request_r;
					rdata_nxt[ULRSD_MPD_BIT] = minus_line_pd_request_r;
				end
				ULRSD_STAT_OFS: begin
					rdata_nxt[ULRSD_PU_BIT] = plus_line_pullup_enable;
					rdata_nxt[ULRSD_PPDEN_BIT] = plus_line_15k_pd_enable;
					rdata_nxt[ULRSD_MPDEN_BIT] = minus_line_15k_pd_enable;
					rdata_nxt[ULRSD_FTERM_BIT] = fast_termination_enable;
				end
				default: begin
					rdata_nxt = '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_sync_b_r) begin
		if (!rst_sync_b_r) begin
			reg_rdata <= ULRSD_RDATA_RST;
		end else begin
			reg_rdata <= rdata_nxt;
		end
	end
endmodule

// ### rtl/ulrsd_pkg.sv
// Constants for the line resistor state decoder.
// Assumes a 100 MHz clock and a plain one-cycle register port.
//
// Behaviour
// - Five controls select the line state
// - Enables follow current control values only
// - Pull-up enable connects plus line pull-up
// - Plus pull-down enable connects plus pull-down
// - Minus pull-down enable connects minus pull-down
// - Termination enable connects both termination resistors
// - Three-state mode clears all four enables
// - Host chirp/test/fast: pull-downs plus termination
// - Host full/low speed: only pull-downs
// - Host resume: only pull-downs
// - OTG peripheral chirp: pull-up, minus pull-down
package ulrsd_pkg;
	localparam int ULRSD_AW = 8;
	localparam int ULRSD_DW = 8;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [ULRSD_AW-1:0] ULRSD_CTRL_OFS = 8'h00;
	localparam logic [ULRSD_AW-1:0] ULRSD_STAT_OFS = 8'h04;

	// ****************************************
	// Control register fields
	// ****************************************
	localparam int ULRSD_XCVR_LSB = 0;
	localparam int ULRSD_TERM_BIT = 2;
	localparam int ULRSD_MODE_LSB = 3;
	localparam int ULRSD_PPD_BIT = 5;
	localparam int ULRSD_MPD_BIT = 6;

	// ****************************************
	// Status register fields
	// ****************************************
	localparam int ULRSD_PU_BIT = 0;
	localparam int ULRSD_PPDEN_BIT = 1;
	localparam int ULRSD_MPDEN_BIT = 2;
	localparam int ULRSD_FTERM_BIT = 3;

	// ****************************************
	// Encodings and reset values
	// ****************************************
	localparam logic [1:0] ULRSD_XCVR_HS = 2'h0;
	localparam logic [1:0] ULRSD_MODE_NODRIVE = 2'h1;

	localparam logic [1:0] ULRSD_XCVR_RST = 2'h1;
	localparam logic ULRSD_TERM_RST = 1'h0;
	localparam logic [1:0] ULRSD_MODE_RST = 2'h0;
	localparam logic ULRSD_PPD_RST = 1'h1;
	localparam logic ULRSD_MPD_RST = 1'h1;
	localparam logic ULRSD_PU_EN_RST = 1'h0;
	localparam logic ULRSD_PPD_EN_RST = 1'h1;
	localparam logic ULRSD_MPD_EN_RST = 1'h1;
	localparam logic ULRSD_FTERM_EN_RST = 1'h0;
	localparam logic [ULRSD_DW-1:0] ULRSD_RDATA_RST = 8'h00;
endpackage

// ### bench/ulrsd_properties.sv
// Port checker for the line resistor decoder.
// Assumes it is bound to ulrsd_top.
`timescale 1ns/1ns
module ulrsd_properties
	import ulrsd_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [ULRSD_AW-1:0] reg_addr,
	input wire logic [ULRSD_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [ULRSD_DW-1:0] reg_rdata,
	input wire logic plus_line_pullup_enable,
	input wire logic plus_line_15k_pd_enable,
	input wire logic minus_line_15k_pd_enable,
	input wire logic fast_termination_enable
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	logic [3:0] en;
	logic [3:0] d;
	logic w0;
	logic off;
	assign en = {fast_termination_enable, minus_line_15k_pd_enable, plus_line_15k_pd_enable, plus_line_pullup_enable};
	assign w0 = reg_wr && reg_addr == ULRSD_CTRL_OFS;
	assign off = reg_wdata[4:3] == ULRSD_MODE_NODRIVE;
	assign d = off ? 4'h0 : {reg_wdata[1:0] == ULRSD_XCVR_HS && !reg_wdata[2], reg_wdata[6:5], reg_wdata[2] && !reg_wdata[5]};
	property p_off; w0 && off |-> ##2 en == 4'h0; endproperty
	a_off: assert property (p_off) else $error("enable on");
	property p_pu; w0 |-> ##2 en[0] == $past(d[0], 2); endproperty
	a_pu: assert property (p_pu) else $error("pullup");
	property p_ppd; w0 |-> ##2 en[1] == $past(d[1], 2); endproperty
	a_ppd: assert property (p_ppd) else $error("plus pd");
	property p_mpd; w0 |-> ##2 en[2] == $past(d[2], 2); endproperty
	a_mpd: assert property (p_mpd) else $error("minus pd");
	property p_term; w0 |-> ##2 en[3] == $past(d[3], 2); endproperty
	a_term: assert property (p_term) else $error("term");
	property p_hold; !reg_wr ##1 !reg_wr |=> $stable(en); endproperty
	a_hold: assert property (p_hold) else $error("moved");
	property p_stat; reg_rd && reg_addr == ULRSD_STAT_OFS |=> reg_rdata == {4'h0, $past(en)}; endproperty
	a_stat: assert property (p_stat) else $error("status");
	property p_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
	a_idle: assert property (p_idle) else $error("rdata");
	c_off: cover property (w0 && off);
	c_otg: cover property (w0 && reg_wdata == 8'h54);
	c_stat: cover property (reg_rd && reg_addr == ULRSD_STAT_OFS);
endmodule
bind ulrsd_top ulrsd_properties ulrsd_properties_inst (
	.clk(clk),
	.rst_b(rst_b),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.reg_rdata(reg_rdata),
	.plus_line_pullup_enable(plus_line_pullup_enable),
	.plus_line_15k_pd_enable(plus_line_15k_pd_enable),
	.minus_line_15k_pd_enable(minus_line_15k_pd_enable),
	.fast_termination_enable(fast_termination_enable)
);

// ### bench/ulrsd_link.sv
// Link model that programs the line controls.
// Assumes the decoder clock.
`timescale 1ns/1ns
module ulrsd_link (
	input wire logic clk,
	input wire logic [7:0] reg_rdata,
	output logic [7:0] reg_addr = 8'h00,
	output logic [7:0] reg_wdata = 8'h00,
	output logic reg_wr = 1'b0,
	output logic reg_rd = 1'b0
);
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v, output logic [7:0] r);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= w;
		reg_rd <= !w;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1 r = reg_rdata;
	endtask
endmodule

// ### bench/usb_line_resistor_state_decode_tb_top.sv
// Bench for the line resistor decoder.
// Assumes the link model drives the register port.
`timescale 1ns/1ns
module usb_line_resistor_state_decode_tb_top;
	import ulrsd_pkg::*;
	logic clk = 0;
	logic rst_b = 0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
	logic reg_wr, reg_rd, plus_line_pullup_enable, plus_line_15k_pd_enable;
	logic minus_line_15k_pd_enable, fast_termination_enable;
	int errors = 0;
	int check_count = 0;
	logic [11:0] tb [11] = '{12'h06f, 12'h661, 12'he70, 12'he60, 12'h667, 12'h675, 12'h676, 12'h114, 12'h800,
		12'h554, 12'hc40};
	logic [7:0] en_port;
	assign en_port = {4'h0, fast_termination_enable, minus_line_15k_pd_enable, plus_line_15k_pd_enable,
		plus_line_pullup_enable};
	ulrsd_link ulrsd_link_inst (
		.clk(clk),
		.reg_rdata(reg_rdata),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd)
	);
	ulrsd_top ulrsd_top_inst (
		.clk(clk),
		.rst_b(rst_b),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.plus_line_pullup_enable(plus_line_pullup_enable),
		.plus_line_15k_pd_enable(plus_line_15k_pd_enable),
		.minus_line_15k_pd_enable(minus_line_15k_pd_enable),
		.fast_termination_enable(fast_termination_enable)
	);
	initial forever #5 clk = ~clk;
	task chk(input logic [7:0] g, input logic [7:0] w);
		check_count++;
		if (g !== w) begin
			errors++;
			$display("wrong value at %0t: %h not %h", $time, g, w);
		end
	endtask
	task close_out;
		$display("%0d checks, %0d mismatches", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst_b <= 1;
		repeat (3) @(posedge clk);
		ulrsd_link_inst.acc(0, ULRSD_STAT_OFS, 0, d);
		chk(d, 8'h06);
		chk(en_port, 8'h06);
		$display("reset values done");
		foreach (tb[i]) begin
			ulrsd_link_inst.acc(1, ULRSD_CTRL_OFS, tb[i][7:0], d);
			ulrsd_link_inst.acc(0, ULRSD_STAT_OFS, 0, d);
			chk(d, {4'h0, tb[i][11:8]});
			chk(en_port, {4'h0, tb[i][11:8]});
		end
		$display("state table done");
		ulrsd_link_inst.acc(1, ULRSD_STAT_OFS, 8'hff, d);
		ulrsd_link_inst.acc(0, 8'h08, 0, d);
		chk(d, 8'h00);
		ulrsd_link_inst.acc(0, ULRSD_CTRL_OFS, 0, d);
		chk(d, 8'h40);
		ulrsd_link_inst.acc(0, ULRSD_STAT_OFS, 0, d);
		chk(d, 8'h0c);
		chk(en_port, 8'h0c);
		$display("refusals done");
		@(posedge clk);
		rst_b <= 0;
		repeat (4) @(posedge clk);
		chk(en_port, 8'h06);
		rst_b <= 1;
		repeat (3) @(posedge clk);
		ulrsd_link_inst.acc(0, ULRSD_CTRL_OFS, 0, d);
		chk(d, 8'h61);
		ulrsd_link_inst.acc(0, ULRSD_STAT_OFS, 0, d);
		chk(d, 8'h06);
		chk(en_port, 8'h06);
		$display("second reset done");
		close_out();
	end
endmodule
